// File: dcsrp_consts.svh
// Purpose: Offsets, field positions, reset values and counts of the serial register port
// Assumes: Included by bare name from the package and the top module
// Notes: Definitions only
`ifndef DCSRP_CONSTS_SVH
`define DCSRP_CONSTS_SVH

// ----------------------------------------
// Frame layout
// ----------------------------------------
`define DCSRP_FRAME_BITS 16
`define DCSRP_CNT_W 5
`define DCSRP_CMD_BIT 15
`define DCSRP_ADDR_HI 14
`define DCSRP_ADDR_LO 8
`define DCSRP_DATA_HI 7
`define DCSRP_DATA_LO 0
`define DCSRP_CMD_READ 1'h1
`define DCSRP_CMD_WRITE 1'h0

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define DCSRP_ADDR_GENERAL_CTRL 7'h00
`define DCSRP_ADDR_OUTPUT_DRIVER_ADJUST 7'h01
`define DCSRP_ADDR_LAUNCH_AMPLITUDE_CTRL 7'h02
`define DCSRP_ADDR_MUTE_REF_CTRL 7'h03
`define DCSRP_ADDR_SPARE_4 7'h04
`define DCSRP_ADDR_SPARE_5 7'h05
`define DCSRP_ADDR_CABLE_LENGTH_ESTIMATE 7'h06
`define DCSRP_ADDR_SPARE_7 7'h07
`define DCSRP_NUM_REGS 8

// ----------------------------------------
// General control fields
// ----------------------------------------
`define DCSRP_GEN_CARRIER_BIT 7
`define DCSRP_GEN_MUTE_BIT 6
`define DCSRP_GEN_BYPASS_BIT 5
`define DCSRP_GEN_SLEEP_HI 4
`define DCSRP_GEN_SLEEP_LO 3
`define DCSRP_GEN_DRVSEL_BIT 2
`define DCSRP_SLEEP_ALWAYS_ON 2'h0
`define DCSRP_SLEEP_ON_NO_INPUT 2'h1
`define DCSRP_SLEEP_FORCED 2'h2
`define DCSRP_SLEEP_RESERVED 2'h3

// ----------------------------------------
// Launch amplitude field
// ----------------------------------------
`define DCSRP_LAUNCH_ATTEN_BIT 7

// ----------------------------------------
// Reset values
// ----------------------------------------
`define DCSRP_RST_MUTE 1'h0
`define DCSRP_RST_BYPASS 1'h0
`define DCSRP_RST_SLEEP 2'h1
`define DCSRP_RST_DRVSEL 1'h0
`define DCSRP_RST_SWING 2'h2
`define DCSRP_RST_CMODE 2'h2
`define DCSRP_RST_DEEMPH_EN 1'h0
`define DCSRP_RST_DEEMPH_LVL 2'h0
`define DCSRP_RST_LAUNCH 1'h0
`define DCSRP_RST_BYTE 8'h00

`endif

// File: dcsrp_host_model.sv
// Purpose: Host serial master for a chain of one device
// Assumes: Serial clock period of eight ref_clk cycles
// Notes: Clock stands low outside frames except in the stray-clock task
`timescale 1ns/1ps
`default_nettype none

module dcsrp_host_model (
  input wire logic ref_clk,
  input wire logic miso_line,
  output logic sck,
  output logic ss_n,
  output logic mosi
);
  initial
  begin
    sck = 1'b0;
    ss_n = 1'b1;
    mosi = 1'b0;
  end

  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  // sixteen clocks per device, one device
  // MSB first, last device's frame first
  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
    wt(1);
    ss_n = 1'b0;
    mosi = tx[15];
    for (int i = 15; i >= 0; i--)
    begin
      wt(4);
      sck = 1'b1;
      wt(4);
      rx[i] = miso_line;
      sck = 1'b0;
      if (i > 0)
        mosi = tx[i-1];
    end
    wt(4);
    ss_n = 1'b1;
    mosi = ~mosi;
    wt(8);
  endtask

  // clock pulses with select high must be ignored
  task automatic stray(input int n);
    for (int i = 0; i < n; i++)
    begin
      mosi = ~mosi;
      wt(4);
      sck = 1'b1;
      wt(4);
      sck = 1'b0;
    end
    wt(8);
  endtask
endmodule
`default_nettype wire

// File: dcsrp_pkg.sv
// Purpose: Types shared by the serial register port
// Assumes: dcsrp_consts.svh on the include path
// Notes: Types only; numbers live in the header
`default_nettype none
`include "dcsrp_consts.svh"

package dcsrp_pkg;

  // ----------------------------------------
  // Output driver settings
  // ----------------------------------------
  typedef struct packed {
    logic [1:0] swing;
    logic [1:0] cmode;
    logic deemph_en;
    logic [1:0] deemph_lvl;
  } dcsrp_drv_t;

  // ----------------------------------------
  // General control settings
  // ----------------------------------------
  typedef struct packed {
    logic mute;
    logic bypass;
    logic [1:0] sleep;
    logic drv_sel;
  } dcsrp_gen_t;

  // ----------------------------------------
  // Whole state of the port
  // ----------------------------------------
  typedef struct packed {
    logic ss_prev;
    logic sck_prev;
    logic [`DCSRP_FRAME_BITS-1:0] shift;
    logic [`DCSRP_CNT_W-1:0] cnt;
    logic miso;
    logic miso_oe;
    dcsrp_gen_t gen;
    dcsrp_drv_t drv0;
    dcsrp_drv_t drv1;
    logic launch;
    logic [`DCSRP_NUM_REGS-1:0][7:0] misc;
    logic sleep_active;
    logic out_muted;
    logic eq_bypassed;
  } dcsrp_state_t;

endpackage

`default_nettype wire

// File: dcsrp_port.sv
// Purpose: Daisy-chainable serial register port of a video cable equalizer
// Assumes: ref_clk at 40 MHz, serial clock well below a third of it
// Notes: Serial clock is sampled, not used as a clock
//
// Summary of operation
// - Serial access only while mode input high
// - Eight 8-bit registers behind the port
// - Frame is 16 bits, bounded by select
// - Read/write bit, 7-bit address, 8 data
// - Sample input rising, change output falling
// - Previous frame shifts out during new one
// - Output driven only while select low
// - Write commits when select returns high
// - Read captures register at select rise
// - Read data in last eight output bits
// - Driver select bit picks driver register
// - Bits 7:6 swing, reset 10
// - Bits 5:4 common mode, reset 10
// - Bit 3 de-emphasis on, 2:1 level
// - Launch bit 7 selects 6 dB input
// - Cable length register reports estimate
// - General bit 7 reports carrier
// - Mute bit 6, bypass bit 5, mute wins
// - Sleep bits 4:3, sleep overrides all
`timescale 1ns/1ps
`default_nettype none
`include "dcsrp_consts.svh"

module dcsrp_port
  import dcsrp_pkg::*;
#(
  parameter int FRAME_BITS = `DCSRP_FRAME_BITS
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic spi_en,
  input wire logic sck,
  input wire logic ss_n,
  input wire logic mosi,
  output logic miso_o,
  output logic miso_oe,
  input wire logic carrier_detect,
  input wire logic [7:0] cable_length_value,
  output dcsrp_drv_t video_out_a_cfg,
  output dcsrp_drv_t video_out_b_cfg,
  output logic launch_atten,
  output logic [7:0] mute_ref_code,
  output logic sleep_active,
  output logic out_muted,
  output logic eq_bypassed
);

  // ----------------------------------------
  // Elaboration check
  // ----------------------------------------
  // The field layout fixes the frame at sixteen bits
  generate
    if (FRAME_BITS != `DCSRP_FRAME_BITS)
    begin : g_bad_frame
      $error("dcsrp_port: frame length must be 16");
    end
  endgenerate

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  logic [1:0] rst_sync_reg;
  logic rst_n;

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rst_sync_reg <= 2'h0;
    end
    else
    begin
      rst_sync_reg <= {rst_sync_reg[0], 1'h1};
    end
  end

  assign rst_n = rst_sync_reg[1];

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [4:0] pins_s;
  logic [7:0] cli_s;
  logic en_s;
  logic ss_s;
  logic sck_s;
  logic mosi_s;
  logic cd_s;

  dcsrp_sync #(
    .W(5),
    .RST_VAL(5'h08)
  ) u_sync_pins (
    .clk(ref_clk),
    .rst_n(rst_n),
    .din({spi_en, ss_n, sck, mosi, carrier_detect}),
    .dout(pins_s)
  );

  // Slow-moving estimate; a torn sample only costs one stale read
  dcsrp_sync #(
    .W(8),
    .RST_VAL(8'h00)
  ) u_sync_cli (
    .clk(ref_clk),
    .rst_n(rst_n),
    .din(cable_length_value),
    .dout(cli_s)
  );

  assign en_s = pins_s[4];
  assign ss_s = pins_s[3];
  assign sck_s = pins_s[2];
  assign mosi_s = pins_s[1];
  assign cd_s = pins_s[0];

  // ----------------------------------------
  // State and next state
  // ----------------------------------------
  dcsrp_state_t state_reg;
  dcsrp_state_t state_next;

  logic sel_fall;
  logic sel_rise;
  logic sck_rise;
  logic sck_fall;
  logic active;
  logic [6:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  dcsrp_drv_t drv_cur;
  dcsrp_drv_t drv_wr;

  assign addr = state_reg.shift[`DCSRP_ADDR_HI:`DCSRP_ADDR_LO];
  assign wdata = state_reg.shift[`DCSRP_DATA_HI:`DCSRP_DATA_LO];

  // ----------------------------------------
  // Read multiplexer
  // ----------------------------------------
  always_comb
  begin
    drv_cur = state_reg.gen.drv_sel ? state_reg.drv1 : state_reg.drv0;
    drv_wr = wdata[7:1];
    rdata = `DCSRP_RST_BYTE;
    unique case (addr)
      `DCSRP_ADDR_GENERAL_CTRL:
      begin
        rdata = {cd_s, state_reg.gen, 2'h0};
      end
      `DCSRP_ADDR_OUTPUT_DRIVER_ADJUST:
      begin
        rdata = {drv_cur, 1'h0};
      end
      `DCSRP_ADDR_LAUNCH_AMPLITUDE_CTRL:
      begin
        rdata = {state_reg.launch, 7'h00};
      end
      `DCSRP_ADDR_CABLE_LENGTH_ESTIMATE:
      begin
        rdata = cli_s;
      end
      `DCSRP_ADDR_MUTE_REF_CTRL, `DCSRP_ADDR_SPARE_4, `DCSRP_ADDR_SPARE_5,
        `DCSRP_ADDR_SPARE_7:
      begin
        rdata = state_reg.misc[addr[2:0]];
      end
      default:
      begin
        rdata = `DCSRP_RST_BYTE;
      end
    endcase
  end

  // ----------------------------------------
  // Serial engine and register file
  // ----------------------------------------
  always_comb
  begin
    state_next = state_reg;
    state_next.ss_prev = ss_s;
    state_next.sck_prev = sck_s;
    // port only live in serial mode
    active = en_s;
    sel_fall = active && state_reg.ss_prev && !ss_s;
    sel_rise = active && !state_reg.ss_prev && ss_s;
    sck_rise = active && !ss_s && !state_reg.ss_prev && !state_reg.sck_prev && sck_s;
    sck_fall = active && !ss_s && !state_reg.ss_prev && state_reg.sck_prev && !sck_s;

    state_next.miso_oe = active && !ss_s;

    if (sel_fall)
    begin
      state_next.cnt = '0;
      // first old bit ready before first clock
      state_next.miso = state_reg.shift[`DCSRP_CMD_BIT];
    end

    if (sck_rise)
    begin
      state_next.shift = {state_reg.shift[FRAME_BITS-2:0], mosi_s};
      if (state_reg.cnt != 5'h1F)
      begin
        state_next.cnt = state_reg.cnt + 5'h01;
      end
    end

    if (sck_fall)
    begin
      state_next.miso = state_reg.shift[`DCSRP_CMD_BIT];
    end

    // act only on a complete frame
    if (sel_rise && state_reg.cnt >= 5'(FRAME_BITS))
    begin
      // command bit selects read or write
      if (state_reg.shift[`DCSRP_CMD_BIT] == `DCSRP_CMD_READ)
      begin
        // capture read data into low byte
        state_next.shift[`DCSRP_DATA_HI:`DCSRP_DATA_LO] = rdata;
      end
      else
      begin
        unique case (addr)
          `DCSRP_ADDR_GENERAL_CTRL:
          begin
            state_next.gen = wdata[6:2];
          end
          `DCSRP_ADDR_OUTPUT_DRIVER_ADJUST:
          begin
            if (state_reg.gen.drv_sel)
            begin
              state_next.drv1 = drv_wr;
            end
            else
            begin
              state_next.drv0 = drv_wr;
            end
          end
          `DCSRP_ADDR_LAUNCH_AMPLITUDE_CTRL:
          begin
            state_next.launch = wdata[`DCSRP_LAUNCH_ATTEN_BIT];
          end
          `DCSRP_ADDR_MUTE_REF_CTRL, `DCSRP_ADDR_SPARE_4, `DCSRP_ADDR_SPARE_5,
            `DCSRP_ADDR_SPARE_7:
          begin
            state_next.misc[addr[2:0]] = wdata;
          end
          default:
          begin
            // Read-only or unmapped address: write dropped
            state_next.misc = state_reg.misc;
          end
        endcase
      end
    end

    unique case (state_reg.gen.sleep)
      `DCSRP_SLEEP_FORCED:
      begin
        state_next.sleep_active = 1'h1;
      end
      `DCSRP_SLEEP_ON_NO_INPUT:
      begin
        state_next.sleep_active = !cd_s;
      end
      default:
      begin
        // Reserved code treated as always on
        state_next.sleep_active = 1'h0;
      end
    endcase
    state_next.out_muted = !state_next.sleep_active && state_reg.gen.mute;
    state_next.eq_bypassed = !state_next.sleep_active && !state_reg.gen.mute &&
      state_reg.gen.bypass;
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg.ss_prev <= 1'h1;
      state_reg.sck_prev <= 1'h0;
      state_reg.shift <= 16'h0000;
      state_reg.cnt <= 5'h00;
      state_reg.miso <= 1'h0;
      state_reg.miso_oe <= 1'h0;
      state_reg.gen.mute <= `DCSRP_RST_MUTE;
      state_reg.gen.bypass <= `DCSRP_RST_BYPASS;
      state_reg.gen.sleep <= `DCSRP_RST_SLEEP;
      state_reg.gen.drv_sel <= `DCSRP_RST_DRVSEL;
      // swing and common mode reset to 10
      state_reg.drv0 <= {`DCSRP_RST_SWING, `DCSRP_RST_CMODE, `DCSRP_RST_DEEMPH_EN,
        `DCSRP_RST_DEEMPH_LVL};
      state_reg.drv1 <= {`DCSRP_RST_SWING, `DCSRP_RST_CMODE, `DCSRP_RST_DEEMPH_EN,
        `DCSRP_RST_DEEMPH_LVL};
      state_reg.launch <= `DCSRP_RST_LAUNCH;
      state_reg.misc <= '0;
      state_reg.sleep_active <= 1'h0;
      state_reg.out_muted <= 1'h0;
      state_reg.eq_bypassed <= 1'h0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign miso_o = state_reg.miso;
  assign miso_oe = state_reg.miso_oe;
  assign video_out_a_cfg = state_reg.drv0;
  assign video_out_b_cfg = state_reg.drv1;
  assign launch_atten = state_reg.launch;
  assign mute_ref_code = state_reg.misc[3];
  assign sleep_active = state_reg.sleep_active;
  assign out_muted = state_reg.out_muted;
  assign eq_bypassed = state_reg.eq_bypassed;

endmodule

`default_nettype wire

// File: dcsrp_port_asserts.sv
// Purpose: Port checks of the serial register port
// Assumes: Bound to dcsrp_port; sync latency of a few ref_clk
// Notes: Windows allow for the input synchronisers
`timescale 1ns/1ps
`default_nettype none

module dcsrp_port_asserts
  import dcsrp_pkg::*;
#(
  parameter int FRAME_BITS = 16
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic spi_en,
  input wire logic sck,
  input wire logic ss_n,
  input wire logic mosi,
  input wire logic miso_o,
  input wire logic miso_oe,
  input wire logic carrier_detect,
  input wire logic [7:0] cable_length_value,
  input wire dcsrp_drv_t video_out_a_cfg,
  input wire dcsrp_drv_t video_out_b_cfg,
  input wire logic launch_atten,
  input wire logic [7:0] mute_ref_code,
  input wire logic sleep_active,
  input wire logic out_muted,
  input wire logic eq_bypassed
);
  logic [3:0] up_reg;

  // Synchronisers are not trusted until well after release
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      up_reg <= 4'h0;
    end
    else if (up_reg != 4'hF)
    begin
      up_reg <= up_reg + 4'h1;
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);

  chk_oe_idle: assert property (ss_n [*7] |-> !miso_oe)
    else $error("miso driven while deselected");
  chk_oe_drive: assert property ((up_reg == 4'hF && spi_en && !ss_n) [*8] |-> miso_oe)
    else $error("miso not driven while selected");
  chk_oe_mode: assert property (!spi_en [*7] |-> !miso_oe)
    else $error("miso driven in pin mode");
  chk_cfg_frozen: assert property (!spi_en [*8] |=>
    $stable({video_out_a_cfg, video_out_b_cfg, launch_atten, mute_ref_code}))
    else $error("config changed in pin mode");
  chk_cfg_commit: assert property (
    !$stable({video_out_a_cfg, video_out_b_cfg, launch_atten, mute_ref_code})
    |-> $past(ss_n, 2) && $past(ss_n, 3))
    else $error("config changed while frame open");
  chk_miso_pace: assert property (miso_oe && $past(miso_oe) && !$stable(miso_o)
    |=> $stable(miso_o) [*6])
    else $error("miso changed twice in one clock period");
  chk_mute_wins: assert property (out_muted |-> !eq_bypassed)
    else $error("bypass active while muted");
  chk_sleep_wins: assert property (sleep_active && $past(sleep_active)
    |-> !out_muted && !eq_bypassed)
    else $error("mute or bypass active in sleep");
  chk_cfg_reset: assert property ($rose(arst_n) |-> video_out_a_cfg == 7'h50
    && video_out_b_cfg == 7'h50 && !launch_atten)
    else $error("driver config not at reset value");
endmodule

bind dcsrp_port dcsrp_port_asserts #(.FRAME_BITS(FRAME_BITS)) dcsrp_port_asserts_inst (
  .ref_clk(ref_clk), .arst_n(arst_n), .spi_en(spi_en), .sck(sck), .ss_n(ss_n),
  .mosi(mosi), .miso_o(miso_o), .miso_oe(miso_oe), .carrier_detect(carrier_detect),
  .cable_length_value(cable_length_value), .video_out_a_cfg(video_out_a_cfg),
  .video_out_b_cfg(video_out_b_cfg), .launch_atten(launch_atten),
  .mute_ref_code(mute_ref_code), .sleep_active(sleep_active), .out_muted(out_muted),
  .eq_bypassed(eq_bypassed)
);
`default_nettype wire

// File: dcsrp_port_tb_top.sv
// Purpose: Self-checking bench of the serial register port
// Assumes: Host model owns select, clock and data
// Notes: Outputs read after select has risen and settled
`timescale 1ns/1ps
`default_nettype none

module dcsrp_port_tb_top;
  import dcsrp_pkg::*;

  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic spi_en = 1'b1;
  logic carrier = 1'b1;
  logic [7:0] cable = 8'hF7;
  logic sck, ss_n, mosi, miso_o, miso_oe, miso_line;
  logic launch_atten, sleep_active, out_muted, eq_bypassed;
  logic [7:0] mute_ref_code;
  dcsrp_drv_t cfg_a, cfg_b;
  logic [15:0] prev;
  bit have_prev = 1'b0;
  int n_mismatch = 0;
  int comparisons = 0;

  always #12.5 ref_clk = ~ref_clk;

  // Released line shows the inverse of its last bit
  assign miso_line = miso_oe ? miso_o : ~miso_o;

  dcsrp_port dcsrp_port_inst (
    .ref_clk(ref_clk), .arst_n(arst_n), .spi_en(spi_en), .sck(sck), .ss_n(ss_n),
    .mosi(mosi), .miso_o(miso_o), .miso_oe(miso_oe), .carrier_detect(carrier),
    .cable_length_value(cable), .video_out_a_cfg(cfg_a), .video_out_b_cfg(cfg_b),
    .launch_atten(launch_atten), .mute_ref_code(mute_ref_code),
    .sleep_active(sleep_active), .out_muted(out_muted), .eq_bypassed(eq_bypassed)
  );
  dcsrp_host_model dcsrp_host_model_inst (
    .ref_clk(ref_clk), .miso_line(miso_line), .sck(sck), .ss_n(ss_n), .mosi(mosi)
  );

  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  function automatic logic [15:0] drv();
    return {2'h0, cfg_b, cfg_a};
  endfunction

  function automatic logic [15:0] stat();
    return {4'h0, sleep_active, out_muted, eq_bypassed, launch_atten, mute_ref_code};
  endfunction

  // Each frame must return the frame held before it
  task automatic fr(input logic [15:0] tx, input logic [15:0] nxt);
    logic [15:0] rx;
    dcsrp_host_model_inst.xfer(tx, rx);
    if (have_prev && spi_en)
      chk("shifted out", prev, rx);
    if (spi_en)
    begin
      prev = nxt;
      have_prev = 1'b1;
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    fr({1'b0, a, d}, {1'b0, a, d});
  endtask

  // Read padded with ones; dummy all ones reads an empty address
  task automatic rd(input logic [6:0] a, input logic [7:0] d);
    fr({1'b1, a, 8'hFF}, {1'b1, a, d});
    fr(16'hFFFF, 16'hFF00);
  endtask

  task automatic t_reset;
    chk("drivers", 16'h2850, drv());
    chk("status", 16'h0000, stat());
    rd(7'h00, 8'h88);
    rd(7'h01, 8'hA0);
    rd(7'h06, 8'hF7);
    cable = 8'h3C;
    wt(10);
    rd(7'h06, 8'h3C);
  endtask

  task automatic t_driver;
    wr(7'h01, 8'h3E);
    chk("driver 0", 16'h281F, drv());
    wr(7'h00, 8'h0C);
    wr(7'h01, 8'hD4);
    chk("driver 1", 16'h351F, drv());
    rd(7'h01, 8'hD4);
    wr(7'h00, 8'h08);
    rd(7'h01, 8'h3E);
  endtask

  task automatic t_ctrl;
    logic [7:0] gv [5] = '{8'hE0, 8'h20, 8'h70, 8'h78, 8'h68};
    logic [15:0] ev [5] = '{16'h0400, 16'h0200, 16'h0800, 16'h0400, 16'h0400};
    for (int i = 0; i < 5; i++)
    begin
      wr(7'h00, gv[i]);
      chk("control", ev[i], stat());
    end
    carrier = 1'b0;
    wt(10);
    chk("no carrier", 16'h0800, stat());
    rd(7'h00, 8'h68);
    carrier = 1'b1;
    wt(10);
    rd(7'h00, 8'hE8);
    wr(7'h00, 8'h08);
  endtask

  task automatic t_regs;
    wr(7'h02, 8'hFF);
    chk("launch", 16'h0100, stat());
    rd(7'h02, 8'h80);
    for (int a = 3; a < 8; a++)
      wr(7'(a), 8'(8'hA0 + a));
    chk("mute ref", 16'h01A3, stat());
    for (int a = 3; a < 8; a++)
      rd(7'(a), (a == 6) ? 8'h3C : 8'(8'hA0 + a));
    rd(7'h08, 8'h00);
    rd(7'h7F, 8'h00);
  endtask

  task automatic t_spi_off;
    spi_en = 1'b0;
    wt(10);
    wr(7'h01, 8'h00);
    chk("frozen", 16'h351F, drv());
    spi_en = 1'b1;
    wt(10);
    rd(7'h01, 8'h3E);
  endtask

  // Stray clocks first, then a known value sent four times, noting the first frame that returns it
  task automatic t_chain;
    logic [15:0] rx;
    int hit = 0;
    dcsrp_host_model_inst.stray(5);
    for (int i = 0; i < 4; i++)
    begin
      dcsrp_host_model_inst.xfer(16'h7F5A, rx);
      if (i == 0)
        chk("after stray clocks", prev, rx);
      if (hit == 0 && rx === 16'h7F5A)
        hit = i + 1;
    end
    chk("chain length", 16'h0002, 16'(hit));
    prev = 16'h7F5A;
  endtask

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial
  begin
    wt(6);
    arst_n = 1'b1;
    wt(12);
    t_reset();
    t_driver();
    t_ctrl();
    t_regs();
    t_spi_off();
    t_chain();
    test_done();
  end

  // Whole run needs about eight thousand cycles
  initial
  begin
    wt(30000);
    n_mismatch++;
    test_done();
  end
endmodule
`default_nettype wire

// File: dcsrp_sync.sv
// Purpose: Three-stage input synchroniser with agreement filter
// Assumes: Inputs asynchronous to clk
// Notes: Output moves only when stages two and three agree
`timescale 1ns/1ps
`default_nettype none

module dcsrp_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  // A zero-width synchroniser has nothing to carry
  generate
    if (W < 1)
    begin : g_bad_width
      $error("dcsrp_sync: width must be at least 1");
    end
  endgenerate

  // Index 0..2 are the stages, index 3 the filtered output
  logic [3:0][W-1:0] state_reg;
  logic [3:0][W-1:0] state_next;

  always_comb
  begin
    state_next[0] = din;
    state_next[1] = state_reg[0];
    state_next[2] = state_reg[1];
    state_next[3] = state_reg[3];
    for (int i = 0; i < W; i++)
    begin
      if (state_reg[1][i] == state_reg[2][i])
      begin
        state_next[3][i] = state_reg[2][i];
      end
    end
  end

  // Constant reset keeps idle levels from glitching the edge finders
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= {4{RST_VAL}};
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign dout = state_reg[3];

endmodule

`default_nettype wire
